//--- inc/dmhp_regs.svh
// Register indices, field positions and reset values of the dual-mode host port
`ifndef DMHP_REGS_SVH
`define DMHP_REGS_SVH

`define DMHP_ADDR_W 3
`define DMHP_DATA_W 8
`define DMHP_NUM_REGS 8
`define DMHP_SYNC_W 16
`define DMHP_MODEM_IN_W 5

`define DMHP_REG_HOLD 3'h0
`define DMHP_REG_IRQ_EN 3'h1
`define DMHP_REG_FEATURE 3'h2
`define DMHP_REG_MODEM_CTRL 3'h4
`define DMHP_REG_LINE_STAT 3'h5
`define DMHP_REG_MODEM_STAT 3'h6

`define DMHP_MCR_DTR 0
`define DMHP_MCR_RTS 1
`define DMHP_MCR_IRQ_OE 3
`define DMHP_MCR_IR_SEL 6
`define DMHP_MCR_IR_INV 7
`define DMHP_EFR_AUTO_RTS 6
`define DMHP_EFR_AUTO_CTS 7
`define DMHP_IER_RTS 6
`define DMHP_IER_CTS 7
`define DMHP_LSR_RX_FULL 0
`define DMHP_LSR_TX_EMPTY 5

`define DMHP_REG_RESET 8'h00
`define DMHP_PIN_IDLE 16'hF800
`define DMHP_MODEM_IDLE 5'h1F

`endif

//--- inc/dmhp_pkg.sv
// Types shared by the dual-mode host port modules
package dmhp_pkg;
    typedef logic [7:0] dmhp_byte_t;
    typedef logic [2:0] dmhp_addr_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } dmhp_state_e;
endpackage

//--- inc/dmhp_chan_if.sv
// Register access path between the bus front end and one channel
interface dmhp_chan_if;
    import dmhp_pkg::*;
    dmhp_addr_t addr;
    dmhp_byte_t wdata;
    logic wr_pulse;
    logic rd_pulse;
    dmhp_byte_t rdata;
    logic irq_en;
    logic irq_pend;
    modport host (output addr, wdata, wr_pulse, rd_pulse, input rdata, irq_en, irq_pend);
    modport chan (input addr, wdata, wr_pulse, rd_pulse, output rdata, irq_en, irq_pend);
endinterface

//--- logic/dmhp_chan.sv
// One channel: register file, ready flags, serial and modem pin roles
`include "dmhp_regs.svh"
module dmhp_chan
    import dmhp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Register access
    dmhp_chan_if.chan bus,
    // Serial and modem pins
    output logic serial_out,
    input wire logic serial_in,
    output logic request_to_send_n,
    input wire logic clear_to_send_n,
    output logic terminal_ready_n,
    input wire logic set_ready_n,
    input wire logic carrier_detect_n,
    input wire logic ring_indicator_n,
    output logic tx_ready_n,
    output logic rx_ready_n,
    output logic user_out_n,
    // Serial engine side
    output dmhp_byte_t tx_byte,
    output logic tx_valid,
    input wire logic tx_take,
    output logic tx_allow,
    input wire logic tx_bit,
    output logic rx_bit,
    input wire dmhp_byte_t rx_byte,
    input wire logic rx_load,
    input wire logic irq_req
);
    dmhp_byte_t regs_ff [`DMHP_NUM_REGS];
    dmhp_byte_t tx_byte_ff;
    dmhp_byte_t rx_byte_ff;
    logic tx_full_ff;
    logic rx_full_ff;
    logic cts_chg_ff;
    logic ser_out_ff;
    logic [`DMHP_MODEM_IN_W-1:0] in1_ff;
    logic [`DMHP_MODEM_IN_W-1:0] in2_ff;
    logic [`DMHP_MODEM_IN_W-1:0] in3_ff;

    wire dmhp_byte_t mcr = regs_ff[`DMHP_REG_MODEM_CTRL];
    wire dmhp_byte_t efr = regs_ff[`DMHP_REG_FEATURE];
    wire dmhp_byte_t ier = regs_ff[`DMHP_REG_IRQ_EN];
    wire rx_s = in2_ff[4];
    wire cts_s = in2_ff[3];
    wire cts_moved = in2_ff[3] ^ in3_ff[3];
    wire wr_hold = bus.wr_pulse && bus.addr == `DMHP_REG_HOLD;
    wire rd_hold = bus.rd_pulse && bus.addr == `DMHP_REG_HOLD;
    wire rd_mstat = bus.rd_pulse && bus.addr == `DMHP_REG_MODEM_STAT;
    wire wr_store = bus.wr_pulse && bus.addr != `DMHP_REG_HOLD && bus.addr != `DMHP_REG_LINE_STAT
                    && bus.addr != `DMHP_REG_MODEM_STAT;

    // Modem status bits read as asserted-high, in cd ri dsr cts order
    function automatic dmhp_byte_t read_mux(input dmhp_addr_t a);
        dmhp_byte_t v;
        v = regs_ff[a];
        if (a == `DMHP_REG_HOLD) begin
            v = rx_byte_ff;
        end else if (a == `DMHP_REG_LINE_STAT) begin
            v = `DMHP_REG_RESET;
            v[`DMHP_LSR_RX_FULL] = rx_full_ff;
            v[`DMHP_LSR_TX_EMPTY] = ~tx_full_ff;
        end else if (a == `DMHP_REG_MODEM_STAT) begin
            v = {~in2_ff[0], ~in2_ff[1], ~in2_ff[2], ~cts_s, 3'h0, cts_chg_ff};
        end
        return v;
    endfunction

    always_ff @(posedge core_clk) begin
        if (srst) begin
            in1_ff <= `DMHP_MODEM_IDLE;
            in2_ff <= `DMHP_MODEM_IDLE;
            in3_ff <= `DMHP_MODEM_IDLE;
        end else begin
            in1_ff <= {serial_in, clear_to_send_n, set_ready_n, ring_indicator_n, carrier_detect_n};
            in2_ff <= in1_ff;
            in3_ff <= in2_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < `DMHP_NUM_REGS; i++) begin
                regs_ff[i] <= `DMHP_REG_RESET;
            end
        end else if (wr_store) begin
            regs_ff[bus.addr] <= bus.wdata;
        end
    end

    // Set wins over clear on every flag
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_full_ff <= 1'b0;
            rx_full_ff <= 1'b0;
            cts_chg_ff <= 1'b0;
            tx_byte_ff <= `DMHP_REG_RESET;
            rx_byte_ff <= `DMHP_REG_RESET;
        end else begin
            tx_full_ff <= wr_hold | (tx_full_ff & ~tx_take);
            rx_full_ff <= rx_load | (rx_full_ff & ~rd_hold);
            cts_chg_ff <= cts_moved | (cts_chg_ff & ~rd_mstat);
            if (wr_hold) begin
                tx_byte_ff <= bus.wdata;
            end
            if (rx_load) begin
                rx_byte_ff <= rx_byte;
            end
        end
    end

    // Standard idles high, infrared idles low
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ser_out_ff <= 1'b1;
        end else begin
            ser_out_ff <= mcr[`DMHP_MCR_IR_SEL] ? ~tx_bit : tx_bit;
        end
    end

    assign serial_out = ser_out_ff;
    assign rx_bit = mcr[`DMHP_MCR_IR_SEL] ? ~(rx_s ^ mcr[`DMHP_MCR_IR_INV]) : rx_s;
    assign tx_ready_n = tx_full_ff;
    assign rx_ready_n = ~rx_full_ff;
    assign tx_byte = tx_byte_ff;
    assign tx_valid = tx_full_ff;
    assign tx_allow = ~(efr[`DMHP_EFR_AUTO_CTS] & cts_s);
    assign request_to_send_n = ~(mcr[`DMHP_MCR_RTS] & ~(efr[`DMHP_EFR_AUTO_RTS] & rx_full_ff));
    assign terminal_ready_n = ~mcr[`DMHP_MCR_DTR];
    assign user_out_n = ~mcr[`DMHP_MCR_IRQ_OE];
    assign bus.irq_en = mcr[`DMHP_MCR_IRQ_OE];
    assign bus.irq_pend = irq_req | (ier[`DMHP_IER_CTS] & cts_chg_ff)
                          | (ier[`DMHP_IER_RTS] & efr[`DMHP_EFR_AUTO_RTS] & rx_full_ff);
    assign bus.rdata = read_mux(bus.addr);
endmodule // dmhp_chan

//--- logic/dmhp_port.sv
// Dual-mode host bus port of a two-channel serial device
`include "dmhp_regs.svh"
// Function
// - Strobe mode: read strobe fall reads register
// - Strobe mode: write strobe rise latches data
// - Line mode: write pin gives direction
// - Strobe mode: one select per channel
// - Line mode: first select selects device
// - Line mode: second select picks channel
// - Strobe mode: channel A irq gated by bit
// - Line mode: shared open-drain low irq
// - Channel B irq gated, off after reset
// - Transmit ready low shows holding space
// - Receive ready low shows data held
// - Standard mode: transmit idles high
// - Infrared mode: transmit idles low
// - Receive idle high, infrared inversion option
// - CTS feeds auto flow or reads back
// - DSR, CD, RI are readable only
// - DTR driven from software
// - Three address bits select register
// - Eight-bit data bus, driven on reads
module dmhp_port
    import dmhp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Host bus pins
    input wire logic bus_mode_sel,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire dmhp_addr_t addr,
    input wire dmhp_byte_t data_in,
    output dmhp_byte_t data_out,
    output logic data_oe,
    // Interrupt pins
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe,
    output logic chan_a_user_out_n,
    output logic chan_b_user_out_n,
    // Channel A pins
    output logic chan_a_tx_ready_n,
    output logic chan_a_rx_ready_n,
    output logic chan_a_serial_out,
    input wire logic chan_a_serial_in,
    output logic chan_a_request_to_send_n,
    input wire logic chan_a_clear_to_send_n,
    output logic chan_a_terminal_ready_n,
    input wire logic chan_a_set_ready_n,
    input wire logic chan_a_carrier_detect_n,
    input wire logic chan_a_ring_indicator_n,
    // Channel B pins
    output logic chan_b_tx_ready_n,
    output logic chan_b_rx_ready_n,
    output logic chan_b_serial_out,
    input wire logic chan_b_serial_in,
    output logic chan_b_request_to_send_n,
    input wire logic chan_b_clear_to_send_n,
    output logic chan_b_terminal_ready_n,
    input wire logic chan_b_set_ready_n,
    input wire logic chan_b_carrier_detect_n,
    input wire logic chan_b_ring_indicator_n,
    // Channel A serial engine
    output dmhp_byte_t chan_a_tx_byte,
    output logic chan_a_tx_valid,
    input wire logic chan_a_tx_take,
    output logic chan_a_tx_allow,
    input wire logic chan_a_tx_bit,
    output logic chan_a_rx_bit,
    input wire dmhp_byte_t chan_a_rx_byte,
    input wire logic chan_a_rx_load,
    input wire logic chan_a_irq_req,
    // Channel B serial engine
    output dmhp_byte_t chan_b_tx_byte,
    output logic chan_b_tx_valid,
    input wire logic chan_b_tx_take,
    output logic chan_b_tx_allow,
    input wire logic chan_b_tx_bit,
    output logic chan_b_rx_bit,
    input wire dmhp_byte_t chan_b_rx_byte,
    input wire logic chan_b_rx_load,
    input wire logic chan_b_irq_req
);
    dmhp_chan_if bus_a ();
    dmhp_chan_if bus_b ();

    // Pin synchroniser and previous sample for edge detection
    logic [`DMHP_SYNC_W-1:0] s1_ff;
    logic [`DMHP_SYNC_W-1:0] s2_ff;
    logic [3:0] prv_ff;

    dmhp_state_e state_ff;
    dmhp_state_e nxt_state;
    logic chan_b_ff;
    dmhp_addr_t addr_ff;
    dmhp_byte_t dout_ff;
    logic irq_a_out_ff;
    logic irq_a_oe_ff;
    logic irq_b_out_ff;
    logic irq_b_oe_ff;

    // Decoded synchronised pins
    wire strobe_mode = s2_ff[15];
    wire rd_n_s = s2_ff[14];
    wire wr_n_s = s2_ff[13];
    wire csa_n_s = s2_ff[12];
    wire csb_n_s = s2_ff[11];
    wire dmhp_addr_t addr_s = s2_ff[10:8];
    wire dmhp_byte_t data_s = s2_ff[7:0];

    wire rd_fall = prv_ff[3] & ~rd_n_s;
    wire wr_fall = prv_ff[2] & ~wr_n_s;
    wire wr_rise = ~prv_ff[2] & wr_n_s;
    wire csa_fall = prv_ff[1] & ~csa_n_s;
    wire csa_rise = ~prv_ff[1] & csa_n_s;

    // Channel A wins if both strobe-mode selects are low
    wire any_sel = ~csa_n_s | ~csb_n_s;
    wire pick_b = strobe_mode ? csa_n_s : csb_n_s;

    wire start_rd_strobe = rd_fall & any_sel & wr_n_s;
    wire start_wr_strobe = wr_fall & any_sel & rd_n_s;
    wire start_rd_line = csa_fall & wr_n_s;
    wire start_wr_line = csa_fall & ~wr_n_s;

    wire idle = state_ff == ST_IDLE;
    wire start_rd = idle & (strobe_mode ? start_rd_strobe : start_rd_line);
    wire start_wr = idle & ~start_rd & (strobe_mode ? start_wr_strobe : start_wr_line);

    // Select of the channel latched at access start in strobe mode, device select in line mode
    wire sel_kept = (strobe_mode & chan_b_ff) ? ~csb_n_s : ~csa_n_s;

    // Read ends on strobe rise or loss of select
    wire end_rd = ~sel_kept | (strobe_mode & rd_n_s);

    // Line mode commits on select rise; strobe mode on write rise
    wire commit_wr = strobe_mode ? (wr_rise & sel_kept) : csa_rise;
    wire abort_wr = strobe_mode & ~sel_kept;
    wire in_write = state_ff == ST_WRITE;
    wire wr_go = in_write & commit_wr;

    // Reads use the live address, writes the one latched at start
    wire dmhp_addr_t acc_addr = idle ? addr_s : addr_ff;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_ff <= `DMHP_PIN_IDLE;
            s2_ff <= `DMHP_PIN_IDLE;
            prv_ff <= 4'hF;
        end else begin
            s1_ff <= {bus_mode_sel, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
                      addr, data_in};
            s2_ff <= s1_ff;
            prv_ff <= {rd_n_s, wr_n_s, csa_n_s, csb_n_s};
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_rd) begin
                    nxt_state = ST_READ;
                end else if (start_wr) begin
                    nxt_state = ST_WRITE;
                end
            end
            ST_READ: begin
                if (end_rd) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (commit_wr | abort_wr) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            chan_b_ff <= 1'b0;
            addr_ff <= `DMHP_ADDR_W'(0);
        end else begin
            state_ff <= nxt_state;
            if (start_rd | start_wr) begin
                chan_b_ff <= pick_b;
                addr_ff <= addr_s;
            end
        end
    end

    // Byte captured at the start so it is stable for the host
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dout_ff <= `DMHP_REG_RESET;
        end else if (start_rd) begin
            dout_ff <= pick_b ? bus_b.rdata : bus_a.rdata;
        end
    end

    assign data_out = dout_ff;
    assign data_oe = state_ff == ST_READ;

    // Channel access strobes
    assign bus_a.addr = acc_addr;
    assign bus_b.addr = acc_addr;
    assign bus_a.wdata = data_s;
    assign bus_b.wdata = data_s;
    assign bus_a.rd_pulse = start_rd & ~pick_b;
    assign bus_b.rd_pulse = start_rd & pick_b;
    assign bus_a.wr_pulse = wr_go & ~chan_b_ff;
    assign bus_b.wr_pulse = wr_go & chan_b_ff;

    // Interrupt pins; line mode shares channel A's pin as open drain
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_a_out_ff <= 1'b0;
            irq_a_oe_ff <= 1'b0;
            irq_b_out_ff <= 1'b0;
            irq_b_oe_ff <= 1'b0;
        end else begin
            if (strobe_mode) begin
                irq_a_out_ff <= bus_a.irq_pend;
                irq_a_oe_ff <= bus_a.irq_en;
            end else begin
                irq_a_out_ff <= 1'b0;
                irq_a_oe_ff <= (bus_a.irq_pend & bus_a.irq_en) | (bus_b.irq_pend & bus_b.irq_en);
            end
            irq_b_out_ff <= bus_b.irq_pend;
            irq_b_oe_ff <= bus_b.irq_en;
        end
    end

    assign chan_a_irq_out = irq_a_out_ff;
    assign chan_a_irq_oe = irq_a_oe_ff;
    assign chan_b_irq_out = irq_b_out_ff;
    assign chan_b_irq_oe = irq_b_oe_ff;

    dmhp_chan u_chan_a (
        .core_clk(core_clk),
        .srst(srst),
        .bus(bus_a.chan),
        .serial_out(chan_a_serial_out),
        .serial_in(chan_a_serial_in),
        .request_to_send_n(chan_a_request_to_send_n),
        .clear_to_send_n(chan_a_clear_to_send_n),
        .terminal_ready_n(chan_a_terminal_ready_n),
        .set_ready_n(chan_a_set_ready_n),
        .carrier_detect_n(chan_a_carrier_detect_n),
        .ring_indicator_n(chan_a_ring_indicator_n),
        .tx_ready_n(chan_a_tx_ready_n),
        .rx_ready_n(chan_a_rx_ready_n),
        .user_out_n(chan_a_user_out_n),
        .tx_byte(chan_a_tx_byte),
        .tx_valid(chan_a_tx_valid),
        .tx_take(chan_a_tx_take),
        .tx_allow(chan_a_tx_allow),
        .tx_bit(chan_a_tx_bit),
        .rx_bit(chan_a_rx_bit),
        .rx_byte(chan_a_rx_byte),
        .rx_load(chan_a_rx_load),
        .irq_req(chan_a_irq_req)
    );

    dmhp_chan u_chan_b (
        .core_clk(core_clk),
        .srst(srst),
        .bus(bus_b.chan),
        .serial_out(chan_b_serial_out),
        .serial_in(chan_b_serial_in),
        .request_to_send_n(chan_b_request_to_send_n),
        .clear_to_send_n(chan_b_clear_to_send_n),
        .terminal_ready_n(chan_b_terminal_ready_n),
        .set_ready_n(chan_b_set_ready_n),
        .carrier_detect_n(chan_b_carrier_detect_n),
        .ring_indicator_n(chan_b_ring_indicator_n),
        .tx_ready_n(chan_b_tx_ready_n),
        .rx_ready_n(chan_b_rx_ready_n),
        .user_out_n(chan_b_user_out_n),
        .tx_byte(chan_b_tx_byte),
        .tx_valid(chan_b_tx_valid),
        .tx_take(chan_b_tx_take),
        .tx_allow(chan_b_tx_allow),
        .tx_bit(chan_b_tx_bit),
        .rx_bit(chan_b_rx_bit),
        .rx_byte(chan_b_rx_byte),
        .rx_load(chan_b_rx_load),
        .irq_req(chan_b_irq_req)
    );
endmodule // dmhp_port

//--- tb/dmhp_port_properties.sv
// Concurrent checks on the dual-mode host port pins
module dmhp_port_properties
    import dmhp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Host bus
    input wire logic bus_mode_sel,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic data_oe,
    // Interrupt and channel pins
    input wire logic chan_a_irq_out,
    input wire logic chan_a_irq_oe,
    input wire logic chan_b_irq_oe,
    input wire logic chan_a_user_out_n,
    input wire logic chan_b_user_out_n,
    input wire logic chan_a_tx_take,
    input wire logic chan_a_tx_ready_n,
    input wire logic chan_b_rx_load,
    input wire logic chan_b_rx_ready_n,
    input wire logic chan_a_serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    a_reset_quiet: assert property (
        $fell(srst) |-> !data_oe && !chan_b_irq_oe && chan_b_user_out_n) else $error("pins not quiet after reset");
    a_serial_idle: assert property (
        $fell(srst) |-> chan_a_serial_out && !chan_a_tx_ready_n) else $error("serial out not idle high");
    a_read_answer: assert property (
        bus_mode_sel && $fell(read_strobe_n) && !chan_a_select_n && write_strobe_n |-> ##[3:5] data_oe)
        else $error("read strobe not answered");
    a_read_float: assert property (
        bus_mode_sel && data_oe |-> !(chan_a_select_n && chan_b_select_n) && write_strobe_n)
        else $error("bus driven outside selected read");
    a_oe_on_read: assert property (
        bus_mode_sel && $rose(data_oe) |-> !read_strobe_n) else $error("bus driven without read");
    a_irq_a_gate: assert property (
        bus_mode_sel && $fell(chan_a_user_out_n) |-> ##[0:1] chan_a_irq_oe) else $error("irq A not enabled");
    a_irq_b_gate: assert property (
        $rose(chan_b_user_out_n) |-> ##[0:1] !chan_b_irq_oe) else $error("irq B not floated");
    a_irq_open_drain: assert property (
        !bus_mode_sel && chan_a_irq_oe |-> !chan_a_irq_out) else $error("shared irq drives high");
    a_tx_drain: assert property (
        chan_a_tx_take |-> ##[1:2] !chan_a_tx_ready_n) else $error("tx ready not restored");
    a_rx_flag: assert property (
        chan_b_rx_load |-> ##[1:2] !chan_b_rx_ready_n) else $error("rx ready not shown");

    c_read: cover property (data_oe ##1 !data_oe);
    c_irq_a: cover property (chan_a_irq_oe && chan_a_irq_out);
    c_shared_irq: cover property (!bus_mode_sel && chan_a_irq_oe);
endmodule // dmhp_port_properties

bind dmhp_port dmhp_port_properties u_props (.core_clk, .srst, .bus_mode_sel, .read_strobe_n, .write_strobe_n,
    .chan_a_select_n, .chan_b_select_n, .data_oe, .chan_a_irq_out, .chan_a_irq_oe, .chan_b_irq_oe,
    .chan_a_user_out_n, .chan_b_user_out_n, .chan_a_tx_take, .chan_a_tx_ready_n, .chan_b_rx_load,
    .chan_b_rx_ready_n, .chan_a_serial_out);

//--- tb/dmhp_host_model.sv
// Host processor model driving the parallel bus pins
module dmhp_host_model
    import dmhp_pkg::*;
(
    // Clock and mode
    input wire logic core_clk,
    input wire logic bus_mode_sel,
    // Bus pins
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic chan_a_select_n,
    output logic chan_b_select_n,
    output dmhp_addr_t addr,
    output dmhp_byte_t data_in,
    input wire dmhp_byte_t data_out,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    dmhp_byte_t wdata_ff;
    logic drive_ff;

    // Released bus shows the inverse byte, never a stale copy
    assign data_in = data_oe ? data_out : (drive_ff ? wdata_ff : ~wdata_ff);

    initial begin
        {read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n} = 4'hF;
        addr = 3'h0;
        wdata_ff = 8'h00;
        drive_ff = 1'h0;
    end

    // Channel code 2 leaves chan_a_select_n high, and chan_b_select_n too in strobe mode
    task automatic cycle(input logic wr, input logic [1:0] ch, input dmhp_addr_t a, input dmhp_byte_t d,
                         output dmhp_byte_t q);
        @(posedge core_clk);
        addr <= a;
        wdata_ff <= d;
        drive_ff <= wr;
        if (bus_mode_sel) begin
            chan_a_select_n <= (ch != 2'h0);
            chan_b_select_n <= (ch != 2'h1);
        end else begin
            write_strobe_n <= ~wr;
            chan_b_select_n <= ch[0];
        end
        repeat (3) @(posedge core_clk);
        if (!bus_mode_sel) chan_a_select_n <= (ch == 2'h2);
        else if (wr) write_strobe_n <= 1'h0;
        else read_strobe_n <= 1'h0;
        repeat (6) @(posedge core_clk);
        q = data_oe ? data_out : 8'hxx;
        read_strobe_n <= 1'h1;
        if (bus_mode_sel) write_strobe_n <= 1'h1;
        else chan_a_select_n <= 1'h1;
        repeat (6) @(posedge core_clk);
        chan_a_select_n <= 1'h1;
        if (bus_mode_sel) chan_b_select_n <= 1'h1;
        write_strobe_n <= 1'h1;
        drive_ff <= 1'h0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule // dmhp_host_model

//--- tb/tb.sv
// Self-checking bench for the dual-mode host port
`include "dmhp_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module tb
    import dmhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, srst, bus_mode_sel, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n;
    logic data_oe;
    dmhp_addr_t addr;
    dmhp_byte_t data_in, data_out;
    wire [1:0] iro, ire, uon, txr, rxr, so, rts, dtr, tv, ta, rb;
    wire dmhp_byte_t txb [2];
    logic [1:0] tk, tbit, sin, cts, dsr, cd, ri, ld, irq;
    dmhp_byte_t rxd [2];
    int n_errors, checks, cycles;

    dmhp_port dut (.core_clk, .srst, .bus_mode_sel, .read_strobe_n, .write_strobe_n, .chan_a_select_n,
        .chan_b_select_n, .addr, .data_in, .data_out, .data_oe,
        .chan_a_irq_out(iro[0]), .chan_a_irq_oe(ire[0]), .chan_b_irq_out(iro[1]), .chan_b_irq_oe(ire[1]),
        .chan_a_user_out_n(uon[0]), .chan_b_user_out_n(uon[1]),
        .chan_a_tx_ready_n(txr[0]), .chan_a_rx_ready_n(rxr[0]), .chan_a_serial_out(so[0]), .chan_a_serial_in(sin[0]),
        .chan_a_request_to_send_n(rts[0]), .chan_a_clear_to_send_n(cts[0]), .chan_a_terminal_ready_n(dtr[0]),
        .chan_a_set_ready_n(dsr[0]), .chan_a_carrier_detect_n(cd[0]), .chan_a_ring_indicator_n(ri[0]),
        .chan_b_tx_ready_n(txr[1]), .chan_b_rx_ready_n(rxr[1]), .chan_b_serial_out(so[1]), .chan_b_serial_in(sin[1]),
        .chan_b_request_to_send_n(rts[1]), .chan_b_clear_to_send_n(cts[1]), .chan_b_terminal_ready_n(dtr[1]),
        .chan_b_set_ready_n(dsr[1]), .chan_b_carrier_detect_n(cd[1]), .chan_b_ring_indicator_n(ri[1]),
        .chan_a_tx_byte(txb[0]), .chan_a_tx_valid(tv[0]), .chan_a_tx_take(tk[0]), .chan_a_tx_allow(ta[0]),
        .chan_a_tx_bit(tbit[0]), .chan_a_rx_bit(rb[0]), .chan_a_rx_byte(rxd[0]), .chan_a_rx_load(ld[0]),
        .chan_a_irq_req(irq[0]), .chan_b_tx_byte(txb[1]), .chan_b_tx_valid(tv[1]), .chan_b_tx_take(tk[1]),
        .chan_b_tx_allow(ta[1]), .chan_b_tx_bit(tbit[1]), .chan_b_rx_bit(rb[1]), .chan_b_rx_byte(rxd[1]),
        .chan_b_rx_load(ld[1]), .chan_b_irq_req(irq[1]));

    dmhp_host_model u_host (.core_clk, .bus_mode_sel, .read_strobe_n, .write_strobe_n, .chan_a_select_n,
        .chan_b_select_n, .addr, .data_in, .data_out, .data_oe);

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    // A hang ends the run as a failure
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [1:0] c, input dmhp_addr_t a, input dmhp_byte_t d);
        dmhp_byte_t q;
        u_host.cycle(1'h1, c, a, d, q);
    endtask

    task automatic rd(input logic [1:0] c, input dmhp_addr_t a, input dmhp_byte_t m, input dmhp_byte_t e);
        dmhp_byte_t q;
        u_host.cycle(1'h0, c, a, 8'h00, q);
        `CHK(q & m, e)
    endtask

    task automatic do_reset(input logic mode);
        @(posedge core_clk);
        srst <= 1'h1;
        bus_mode_sel <= mode;
        tick(8);
        srst <= 1'h0;
        tick(1);
    endtask

    task automatic t_reset();
        `CHK({data_oe, ire, uon, txr, rxr, so, rts, dtr, ta, tv, rb}, 21'h3_3FF3)
        rd(2'h1, `DMHP_REG_MODEM_CTRL, 8'hFF, 8'h00);
    endtask

    task automatic t_strobe();
        wr(2'h0, 3'h3, 8'h5A);
        wr(2'h1, 3'h3, 8'hA5);
        wr(2'h0, 3'h7, 8'h3C);
        wr(2'h2, 3'h3, 8'hFF);
        rd(2'h0, 3'h3, 8'hFF, 8'h5A);
        rd(2'h1, 3'h3, 8'hFF, 8'hA5);
        rd(2'h0, 3'h7, 8'hFF, 8'h3C);
        rd(2'h2, 3'h3, 8'hFF, 8'hxx);
    endtask

    task automatic t_modem();
        wr(2'h0, `DMHP_REG_MODEM_CTRL, 8'h0B);
        wr(2'h1, `DMHP_REG_MODEM_CTRL, 8'h08);
        `CHK({dtr[0], rts[0], uon, ire}, 6'h03)
        irq <= 2'h3;
        tick(4);
        `CHK(iro, 2'h3)
        irq <= 2'h0;
        wr(2'h0, `DMHP_REG_MODEM_CTRL, 8'h00);
        wr(2'h1, `DMHP_REG_MODEM_CTRL, 8'h00);
        `CHK({uon, ire}, 4'hC)
    endtask

    task automatic t_txrx();
        wr(2'h0, `DMHP_REG_HOLD, 8'h96);
        `CHK({txr[0], tv[0], txb[0]}, 10'h396)
        rd(2'h0, `DMHP_REG_LINE_STAT, 8'h21, 8'h00);
        tk[0] <= 1'h1;
        tick(1);
        tk[0] <= 1'h0;
        tick(2);
        `CHK(txr[0], 1'h0)
        rxd[0] <= 8'hC3;
        rxd[1] <= 8'h3C;
        ld <= 2'h3;
        tick(1);
        ld <= 2'h0;
        tick(2);
        `CHK(rxr, 2'h0)
        rd(2'h0, `DMHP_REG_HOLD, 8'hFF, 8'hC3);
        rd(2'h1, `DMHP_REG_HOLD, 8'hFF, 8'h3C);
        `CHK(rxr, 2'h3)
    endtask

    task automatic t_serial();
        sin[0] <= 1'h0;
        tick(4);
        `CHK(rb[0], 1'h0)
        sin[0] <= 1'h1;
        tbit[0] <= 1'h0;
        tick(4);
        `CHK({rb[0], so[0]}, 2'h2)
        tbit[0] <= 1'h1;
        wr(2'h0, `DMHP_REG_MODEM_CTRL, 8'h40);
        `CHK(so[0], 1'h0)
        tbit[0] <= 1'h0;
        tick(3);
        `CHK({rb[0], so[0]}, 2'h1)
        wr(2'h0, `DMHP_REG_MODEM_CTRL, 8'hC0);
        `CHK({rb[0], so[0]}, 2'h3)
    endtask

    task automatic t_status();
        cts[0] <= 1'h0;
        dsr[0] <= 1'h0;
        cd[0] <= 1'h0;
        tick(4);
        rd(2'h0, `DMHP_REG_MODEM_STAT, 8'hF1, 8'hB1);
        rd(2'h0, `DMHP_REG_MODEM_STAT, 8'hF1, 8'hB0);
        wr(2'h0, `DMHP_REG_FEATURE, 8'h80);
        `CHK(ta[0], 1'h1)
        cts[0] <= 1'h1;
        tick(4);
        `CHK(ta[0], 1'h0)
    endtask

    task automatic t_line();
        wr(2'h0, 3'h3, 8'h11);
        wr(2'h1, 3'h3, 8'h22);
        wr(2'h2, 3'h3, 8'h33);
        rd(2'h0, 3'h3, 8'hFF, 8'h11);
        rd(2'h1, 3'h3, 8'hFF, 8'h22);
        wr(2'h0, `DMHP_REG_MODEM_CTRL, 8'h08);
        irq <= 2'h2;
        tick(4);
        `CHK(ire[0], 1'h0)
        wr(2'h1, `DMHP_REG_MODEM_CTRL, 8'h08);
        `CHK({ire[0], iro[0]}, 2'h2)
        irq <= 2'h0;
    endtask

    initial begin
        {tk, ld, irq} = '0;
        {tbit, sin, cts, dsr, cd, ri} = '1;
        rxd[0] = 8'h00;
        rxd[1] = 8'h00;
        srst = 1'h1;
        bus_mode_sel = 1'h1;
        do_reset(1'h1);
        t_reset();
        t_strobe();
        t_modem();
        t_txrx();
        t_serial();
        t_status();
        do_reset(1'h0);
        t_line();
        conclude();
    end
endmodule // tb
